// [src/fbci_host.v]
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
module fbci_host (
    input  wire        mclk,               // system clock
    input  wire        rst_n,              // async reset, active low
    input  wire        clkEn,              // freezes state when low
    input  wire [3:0]  regAddr,            // software register index
    input  wire [15:0] regWdata,           // software write data
    input  wire        regWr,              // write strobe
    input  wire        regRd,              // read strobe
    output reg  [15:0] regRdata_r,         // read data, cycle after strobe
    output reg  [17:0] flashAddr_r,        // address pins
    output reg  [15:0] flashDqOut_r,       // data pins out
    output reg         flashDqOe_r,        // low byte lines driven
    output reg         flashDqHiOe_r,      // lines eight to fourteen driven
    output reg         flashTopOe_r,       // upper_data_or_byte_lsb driven
    input  wire [15:0] flashDqIn,          // data pins in
    output reg         flashChipEn_n_r,    // chip enable
    output reg         flashOutEn_n_r,     // output enable
    output reg         flashWrEn_n_r,      // write enable
    output reg         flashByteWord_r,    // width select, high is x16
    output reg         reset_unprotect_n,  // reset input of the device
    output reg         unprotHv_r,         // reset input at high voltage
    output reg         sigAddrHv_r,        // high_voltage_address_pin raised
    input  wire        ready_busy_n        // open-drain ready/busy pin
);
`include "fbci_defs.vh"
    localparam [5:0] ST_IDLE = 6'h01;  // waiting for go
    localparam [5:0] ST_SET  = 6'h02;  // drive address and data, strobe low
    localparam [5:0] ST_HOLD = 6'h04;  // strobe high, next cycle
    localparam [5:0] ST_READ = 6'h08;  // read cycle
    localparam [5:0] ST_RSTL = 6'h10;  // reset held low
    localparam [5:0] ST_RSTW = 6'h20;  // reset recovery
    reg  [5:0]  state_r;     // sequencer state
    reg  [2:0]  op_r;        // latched operation
    reg  [2:0]  idx_r;       // write cycle index
    reg  [2:0]  last_r;      // last write cycle index
    reg  [17:0] userAddr_r;  // software address
    reg         userLsb_r;   // byte lsb in byte mode
    reg  [15:0] userData_r;  // software data
    reg  [`FBCI_CNT_W-1:0] cnt_r;  // phase timer
    reg         refused_r;   // sticky: busy refusal
    reg  [1:0]  rbSync_r;    // ready/busy synchroniser
    reg  [15:0] dqSync1_r;   // data synchroniser stage one
    reg  [15:0] dqSync2_r;   // data synchroniser stage two
    reg  [15:0] rdHold_r;    // data taken at end of read
    wire [18:0] romAddr;     // sequence address
    wire [7:0]  romData;     // sequence data
    wire        romUser;     // use software address/data
    wire        busyDev = ~rbSync_r[1];
    //////////////////////////////////////////////////////////////////
    // sequence table
    fbci_seq_rom uRom (
        .mclk     (mclk),
        .clkEn    (clkEn),
        .op       (op_r),
        .idx      (idx_r),
        .wordMode (flashByteWord_r),
        .romAddr  (romAddr),
        .romData  (romData),
        .romUser  (romUser)
    );
    //////////////////////////////////////////////////////////////////
    // input synchronisers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rbSync_r  <= 2'h3;
            dqSync1_r <= 16'h0000;
            dqSync2_r <= 16'h0000;
        end else if (clkEn) begin
            rbSync_r  <= {rbSync_r[0], ready_busy_n};
            dqSync1_r <= flashDqIn;
            dqSync2_r <= dqSync1_r;
        end
    end
    //////////////////////////////////////////////////////////////////
    // sequencer and register file
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r           <= ST_IDLE;
            op_r              <= `FBCI_OP_READ;
            idx_r             <= 3'h0;
            last_r            <= 3'h0;
            userAddr_r        <= 18'h00000;
            userLsb_r         <= 1'b0;
            userData_r        <= 16'h0000;
            cnt_r             <= {`FBCI_CNT_W{1'b0}};
            refused_r         <= 1'b0;
            regRdata_r        <= 16'h0000;
            rdHold_r          <= 16'h0000;
            flashAddr_r       <= 18'h00000;
            flashDqOut_r      <= 16'h0000;
            flashDqOe_r       <= 1'b0;
            flashDqHiOe_r     <= 1'b0;
            flashTopOe_r      <= 1'b0;
            flashChipEn_n_r   <= 1'b1;
            flashOutEn_n_r    <= 1'b1;
            flashWrEn_n_r     <= 1'b1;
            flashByteWord_r   <= 1'b1;
            reset_unprotect_n <= 1'b1;
            unprotHv_r        <= 1'b0;
            sigAddrHv_r       <= 1'b0;
        end else if (clkEn) begin
            // register reads, data one cycle later
            if (regRd) begin
                case (regAddr)
                    `FBCI_REG_CTRL:   regRdata_r <= {8'h00, ~reset_unprotect_n, sigAddrHv_r, unprotHv_r,
                                                     flashByteWord_r, op_r, 1'b0};
                    `FBCI_REG_ADDR:   regRdata_r <= userAddr_r[15:0];
                    `FBCI_REG_WDATA:  regRdata_r <= userData_r;
                    `FBCI_REG_RDATA:  regRdata_r <= rdHold_r;
                    `FBCI_REG_STATUS: regRdata_r <= {13'h0000, refused_r, rbSync_r[1], ~state_r[0]};
                    default:          regRdata_r <= 16'h0000;
                endcase
            end
            if (regWr && regAddr == `FBCI_REG_ADDR) begin
                userAddr_r <= {regWdata[15:0], 2'h0} >> 2;
            end
            if (regWr && regAddr == `FBCI_REG_WDATA) begin
                userData_r <= regWdata;
            end
            if (regWr && regAddr == (`FBCI_REG_ADDR + 4'h5)) begin
                userAddr_r[17:16] <= regWdata[1:0];  // upper address bits
                userLsb_r         <= regWdata[2];
            end
            if (regWr && regAddr == `FBCI_REG_STATUS && regWdata[`FBCI_STAT_REFUSED]) begin
                refused_r <= 1'b0;
            end
            cnt_r <= (cnt_r == {`FBCI_CNT_W{1'b0}}) ? cnt_r : cnt_r - 1'b1;
            case (state_r)
                ST_IDLE: begin
                    flashChipEn_n_r <= 1'b1;
                    flashOutEn_n_r  <= 1'b1;
                    flashWrEn_n_r   <= 1'b1;
                    flashDqOe_r     <= 1'b0;
                    flashDqHiOe_r   <= 1'b0;
                    flashTopOe_r    <= 1'b0;
                    if (regWr && regAddr == `FBCI_REG_CTRL) begin
                        flashByteWord_r <= regWdata[`FBCI_CTRL_WORD];
                        unprotHv_r      <= regWdata[`FBCI_CTRL_UNPROT];
                        sigAddrHv_r     <= regWdata[`FBCI_CTRL_HVSIG];
                        op_r            <= regWdata[`FBCI_CTRL_OP_MSB:`FBCI_CTRL_OP_LSB];
                        idx_r           <= 3'h0;
                        cnt_r           <= `FBCI_PHASE_CYC + 8'h02;
                        if (regWdata[`FBCI_CTRL_RESET]) begin
                            reset_unprotect_n <= 1'b0;
                            cnt_r   <= `FBCI_RSTPULSE_CYC;
                            state_r <= ST_RSTL;
                        end else if (regWdata[`FBCI_CTRL_GO]) begin
                            case (regWdata[`FBCI_CTRL_OP_MSB:`FBCI_CTRL_OP_LSB])
                                `FBCI_OP_READ: state_r <= ST_READ;
                                `FBCI_OP_SUSPEND, `FBCI_OP_RESUME, `FBCI_OP_READRESET: begin
                                    idx_r   <= 3'h2;  // single write cycle
                                    last_r  <= 3'h2;
                                    state_r <= ST_SET;
                                end
                                default: begin
                                    // busy device: program, erase and signature are refused
                                    if (busyDev) begin
                                        refused_r <= 1'b1;
                                    end else begin
                                        last_r  <= (regWdata[2:1] == 2'h1) ? 3'h3 :
                                                   (regWdata[3:1] == `FBCI_OP_SIGNATURE) ? 3'h2 : 3'h5;
                                        state_r <= ST_SET;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_SET: begin
                    // write cycle: chip and write low, output high
                    flashChipEn_n_r <= 1'b0;
                    flashOutEn_n_r  <= 1'b1;
                    // strobe falls once the registered table output has settled
                    flashWrEn_n_r   <= (cnt_r > `FBCI_PHASE_CYC);
                    flashDqOe_r     <= 1'b1;
                    flashDqHiOe_r   <= flashByteWord_r;
                    flashTopOe_r    <= 1'b1;  // data bit or byte address
                    if (romUser) begin
                        flashAddr_r  <= userAddr_r;
                        // block erase confirm keeps the table command
                        flashDqOut_r <= (op_r != `FBCI_OP_PROGRAM) ? {userLsb_r, 7'h00, romData} :
                                        flashByteWord_r ? userData_r : {userLsb_r, 7'h00, userData_r[7:0]};
                    end else if (idx_r == 3'h2 && last_r == 3'h2 && op_r != `FBCI_OP_SIGNATURE) begin
                        flashDqOut_r <= {8'h00, (op_r == `FBCI_OP_SUSPEND) ? `FBCI_CMD_SUSPEND :
                                         (op_r == `FBCI_OP_RESUME) ? `FBCI_CMD_RESUME : `FBCI_CMD_READRST};
                    end else begin
                        flashAddr_r  <= flashByteWord_r ? romAddr[17:0] : romAddr[18:1];
                        flashDqOut_r <= {flashByteWord_r ? 1'b0 : romAddr[0], 7'h00, romData};
                    end
                    if (cnt_r == {`FBCI_CNT_W{1'b0}}) begin
                        flashWrEn_n_r <= 1'b1;  // data taken on this rise
                        cnt_r         <= `FBCI_PHASE_CYC;
                        state_r       <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    flashChipEn_n_r <= 1'b1;
                    if (cnt_r == {`FBCI_CNT_W{1'b0}}) begin
                        cnt_r <= `FBCI_PHASE_CYC + 8'h02;
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == last_r) begin
                            state_r <= (op_r == `FBCI_OP_SIGNATURE) ? ST_READ : ST_IDLE;
                        end else begin
                            state_r <= ST_SET;
                        end
                    end
                end
                ST_READ: begin
                    // read: chip and output low
                    flashChipEn_n_r <= 1'b0;
                    flashOutEn_n_r  <= 1'b0;
                    flashWrEn_n_r   <= 1'b1;
                    flashDqOe_r     <= 1'b0;
                    flashDqHiOe_r   <= 1'b0;
                    flashTopOe_r    <= ~flashByteWord_r;  // byte lsb stays an address
                    flashDqOut_r    <= {userLsb_r, 15'h0000};
                    flashAddr_r     <= userAddr_r;
                    if (cnt_r == {`FBCI_CNT_W{1'b0}}) begin
                        state_r  <= ST_IDLE;  // data lands in the read register
                        rdHold_r <= dqSync2_r;
                    end
                end
                ST_RSTL: begin
                    if (cnt_r == {`FBCI_CNT_W{1'b0}}) begin
                        reset_unprotect_n <= 1'b1;
                        cnt_r   <= `FBCI_RSTREC_CYC;
                        state_r <= ST_RSTW;
                    end
                end
                ST_RSTW: begin
                    // wait recovery and for ready/busy to rise
                    if (cnt_r == {`FBCI_CNT_W{1'b0}} && !busyDev) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// [include/fbci_defs.vh]
`ifndef FBCI_DEFS_VH
`define FBCI_DEFS_VH
// software register offsets (word index on the plain port)
`define FBCI_REG_CTRL      4'h0
`define FBCI_REG_ADDR      4'h1
`define FBCI_REG_WDATA     4'h2
`define FBCI_REG_RDATA     4'h3
`define FBCI_REG_STATUS    4'h4
// control register fields
`define FBCI_CTRL_GO       0
`define FBCI_CTRL_OP_LSB   1
`define FBCI_CTRL_OP_MSB   3
`define FBCI_CTRL_WORD     4
`define FBCI_CTRL_UNPROT   5
`define FBCI_CTRL_HVSIG    6
`define FBCI_CTRL_RESET    7
// operations written to the control register
`define FBCI_OP_READ       3'h0
`define FBCI_OP_PROGRAM    3'h1
`define FBCI_OP_BLKERASE   3'h2
`define FBCI_OP_CHIPERASE  3'h3
`define FBCI_OP_SIGNATURE  3'h4
`define FBCI_OP_SUSPEND    3'h5
`define FBCI_OP_RESUME     3'h6
`define FBCI_OP_READRESET  3'h7
// status register fields
`define FBCI_STAT_BUSY     0
`define FBCI_STAT_RDYBSY   1
`define FBCI_STAT_REFUSED  2
// command codes
`define FBCI_CMD_UNLOCK1   8'hAA
`define FBCI_CMD_UNLOCK2   8'h55
`define FBCI_CMD_PROGRAM   8'hA0
`define FBCI_CMD_ERASESET  8'h80
`define FBCI_CMD_BLKCONF   8'h30
`define FBCI_CMD_CHIPCONF  8'h10
`define FBCI_CMD_SIGNATURE 8'h90
`define FBCI_CMD_SUSPEND   8'hB0
`define FBCI_CMD_RESUME    8'h30
`define FBCI_CMD_READRST   8'hF0
// unlock addresses, word and byte mode
`define FBCI_UADDR1_W      19'h05555
`define FBCI_UADDR2_W      19'h02AAA
`define FBCI_UADDR1_B      19'h0AAAA
`define FBCI_UADDR2_B      19'h05555
// timing (ns) and derived counts at 20 ns period
`define FBCI_CLK_NS        20
`define FBCI_PHASE_NS      100
`define FBCI_PHASE_CYC     8'h05
`define FBCI_RSTPULSE_NS   500
`define FBCI_RSTPULSE_CYC  8'h19
`define FBCI_RSTREC_NS     1000
`define FBCI_RSTREC_CYC    8'h32
`define FBCI_CNT_W         8
`endif

// [src/fbci_seq_rom.v]
`timescale 1ns/100ps
// registered lookup of the write cycles of each instruction
module fbci_seq_rom (
    input  wire        mclk,      // system clock
    input  wire        clkEn,     // freezes state when low
    input  wire [2:0]  op,        // selected operation
    input  wire [2:0]  idx,       // write cycle index
    input  wire        wordMode,  // x16 when high
    output reg  [18:0] romAddr,   // address of this cycle
    output reg  [7:0]  romData,   // data of this cycle
    output reg         romUser    // use caller's address, and caller's data when programming
);
`include "fbci_defs.vh"
    wire [18:0] u1 = wordMode ? `FBCI_UADDR1_W : `FBCI_UADDR1_B;  // first unlock address
    wire [18:0] u2 = wordMode ? `FBCI_UADDR2_W : `FBCI_UADDR2_B;  // second unlock address
    //////////////////////////////////////////////////////////////////
    // table lookup, registered
    always @(posedge mclk) begin
        if (clkEn) begin
            romUser <= 1'b0;
            case (idx)
                3'h0, 3'h3: begin
                    romAddr <= u1;
                    romData <= `FBCI_CMD_UNLOCK1;
                end
                3'h1, 3'h4: begin
                    romAddr <= u2;
                    romData <= `FBCI_CMD_UNLOCK2;
                end
                default: begin
                    romAddr <= u1;
                    case (op)
                        `FBCI_OP_PROGRAM:   romData <= `FBCI_CMD_PROGRAM;
                        `FBCI_OP_BLKERASE,
                        `FBCI_OP_CHIPERASE: romData <= `FBCI_CMD_ERASESET;
                        `FBCI_OP_SIGNATURE: romData <= `FBCI_CMD_SIGNATURE;
                        default:            romData <= `FBCI_CMD_READRST;
                    endcase
                    // erase confirm on the sixth write cycle
                    if (idx == 3'h5) begin
                        romData <= (op == `FBCI_OP_CHIPERASE) ? `FBCI_CMD_CHIPCONF : `FBCI_CMD_BLKCONF;
                        romUser <= (op == `FBCI_OP_BLKERASE);
                    end
                end
            endcase
            if (idx == 3'h3 && op == `FBCI_OP_PROGRAM) begin
                romUser <= 1'b1;
            end
        end
    end
endmodule

// [verification/fbci_host_properties.sv]
`timescale 1ns/100ps
// pin-level checks on the controller side of the flash bus
module fbci_host_properties (
    input wire        mclk,             // system clock
    input wire        rst_n,            // async reset, active low
    input wire [17:0] flashAddr_r,      // address pins
    input wire [15:0] flashDqOut_r,     // data pins out
    input wire        flashDqOe_r,      // low byte driven
    input wire        flashDqHiOe_r,    // lines eight to fourteen driven
    input wire        flashChipEn_n_r,  // chip enable
    input wire        flashOutEn_n_r,   // output enable
    input wire        flashWrEn_n_r,    // write enable
    input wire        flashByteWord_r,  // width select
    input wire        reset_unprotect_n // device reset
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // write strobe opens, then stays low for a full set-up phase
    sequence s_wr_open;
        $fell(flashWrEn_n_r);
    endsequence
    sequence s_wr_hold;
        !flashWrEn_n_r [*5];
    endsequence
    ////////////////////////////////////////////////////////////////
    a_write_output_off: assert property (!flashWrEn_n_r |-> flashOutEn_n_r && !flashChipEn_n_r)
        else $error("write strobe without chip select or with output enabled");
    a_addr_steady: assert property (!flashWrEn_n_r && $past(!flashWrEn_n_r) |-> $stable(flashAddr_r))
        else $error("address moved during write strobe");
    a_data_steady: assert property (!flashWrEn_n_r && $past(!flashWrEn_n_r) |-> $stable(flashDqOut_r) && flashDqOe_r)
        else $error("write data not held while strobe low");
    a_we_pulse_len: assert property (s_wr_open |-> s_wr_hold)
        else $error("write strobe shorter than one phase");
    a_no_contention: assert property (!flashOutEn_n_r |-> !flashDqOe_r && !flashDqHiOe_r)
        else $error("controller drives data while device outputs enabled");
    a_read_selects: assert property (!flashOutEn_n_r |-> !flashChipEn_n_r)
        else $error("output enable without chip select");
    a_byte_hi_float: assert property (!flashByteWord_r |-> !flashDqHiOe_r)
        else $error("upper lines driven in byte mode");
    a_reset_pulse: assert property ($fell(reset_unprotect_n) |=> !reset_unprotect_n [*8])
        else $error("device reset pulse too short");
endmodule
bind fbci_host fbci_host_properties i_props (.*);

// [verification/fbci_flash_model.sv]
`timescale 1ns/100ps
`include "fbci_defs.vh"
// behavioural flash device facing the controller
module fbci_flash_model #(
    parameter       BUSY_NS = 4000,  // engine run time
    parameter       RST_NS  = 2000,  // reset recovery while busy
    parameter [7:0] MAKER   = 8'h5A, // arbitrary maker code
    parameter [7:0] PART    = 8'hC3  // arbitrary part code
) (
    input  wire        mclk,
    input  wire [17:0] addr,
    input  wire [15:0] dqOut,
    input  wire        ceN,
    input  wire        oeN,
    input  wire        weN,
    input  wire        byteWord,
    input  wire        rstN,
    input  wire        sigHv,
    output reg  [15:0] dqIn,
    output wire        rbN
);
    reg  [18:0] progAddr, latAddr;  // programmed and latched address
    reg  [15:0] progData, rdVal, lastVal;
    reg  [2:0]  cyc;                // position in the coded sequence
    reg  [7:0]  cmd;                // set-up command
    reg         sig, memOk, tog, engaged;
    time        endAt, remain;
    integer     wrCount, rstLow, lastRst;
    wire        wrAct = !ceN && !weN && oeN;
    wire        rdAct = !ceN && !oeN && weN && rstN;
    wire [18:0] fullAddr = byteWord ? {1'b0, addr} : {addr, dqOut[15]};
    assign rbN = !engaged;
    initial begin
        cyc = 0; sig = 0; memOk = 0; tog = 0; engaged = 0; endAt = 0; wrCount = 0; rstLow = 0; lastRst = 0;
        remain = 0;
        lastVal = 16'h5AA5;
    end
    // unlock check on low byte only, address per width
    function ok(input [7:0] d, input [18:0] aw, input [18:0] ab);
        ok = dqOut[7:0] == d && latAddr == (byteWord ? aw : ab);
    endfunction
    always @(posedge wrAct) latAddr = fullAddr;
    // command decoder, taken at the early rising strobe
    always @(negedge wrAct) if (rstN) begin
        wrCount = wrCount + 1;
        sig = 0;
        if ($time < endAt) begin
            if (dqOut[7:0] == `FBCI_CMD_SUSPEND) begin
                remain = endAt - $time;
                endAt = 0;
            end
        end else if (remain != 0 && dqOut[7:0] == `FBCI_CMD_RESUME) begin
            endAt = $time + remain;
            remain = 0;
        end else if (cyc == 3 && cmd == `FBCI_CMD_PROGRAM) begin
            progAddr = latAddr;
            progData = dqOut;
            memOk = 1;
            endAt = $time + BUSY_NS;
            cyc = 0;
        end else if (cyc == 0 || cyc == 3) cyc = ok(`FBCI_CMD_UNLOCK1, `FBCI_UADDR1_W, `FBCI_UADDR1_B) ? cyc + 1 : 0;
        else if (cyc == 1 || cyc == 4) cyc = ok(`FBCI_CMD_UNLOCK2, `FBCI_UADDR2_W, `FBCI_UADDR2_B) ? cyc + 1 : 0;
        else if (cyc == 2) begin
            cmd = dqOut[7:0];
            sig = ok(`FBCI_CMD_SIGNATURE, `FBCI_UADDR1_W, `FBCI_UADDR1_B);
            cyc = (ok(`FBCI_CMD_PROGRAM, `FBCI_UADDR1_W, `FBCI_UADDR1_B) || ok(`FBCI_CMD_ERASESET, `FBCI_UADDR1_W,
                  `FBCI_UADDR1_B)) ? 3 : 0;
        end else begin
            if (cmd == `FBCI_CMD_ERASESET && (dqOut[7:0] == `FBCI_CMD_BLKCONF || dqOut[7:0] == `FBCI_CMD_CHIPCONF)) begin
                memOk = 0;
                endAt = $time + BUSY_NS;
            end
            cyc = 0;
        end
    end
    // hardware reset drops the decoder, ends a running or suspended engine RST_NS later
    always @(negedge rstN) begin
        cyc = 0;
        sig = 0;
        if ($time < endAt || remain != 0) endAt = $time + RST_NS;
        remain = 0;
    end
    always @(posedge ceN or posedge oeN) tog = !tog;
    // engine state, reset pulse length and last driven value
    always @(posedge mclk) begin
        engaged <= $time < endAt;
        if (!rstN) rstLow <= rstLow + 1;
        else if (rstLow != 0) begin
            lastRst <= rstLow;
            rstLow <= 0;
        end
        if (rdAct) lastVal <= dqIn;
    end
    // read path, released lines show the inverse of the last value
    always @* begin
        if (engaged) rdVal = {8'h00, ~progData[7], tog, 3'b000, tog, 2'b00};
        else if (sig || (sigHv && !addr[1])) rdVal = {8'h00, addr[0] ? PART : MAKER};
        else rdVal = (memOk && fullAddr == progAddr) ? progData : 16'hFFFF;
        if (!byteWord) rdVal[15:8] = ~lastVal[15:8];
        dqIn = rdAct ? rdVal : ~lastVal;
    end
endmodule

// [verification/testbench.sv]
`timescale 1ns/100ps
`include "fbci_defs.vh"
module testbench;
    reg         mclk, rst_n, regWr, regRd;
    reg  [3:0]  regAddr;
    reg  [15:0] regWdata, rd;
    wire [15:0] regRdata_r, flashDqOut_r, flashDqIn;
    wire [17:0] flashAddr_r;
    wire        flashDqOe_r, flashDqHiOe_r, flashTopOe_r, flashChipEn_n_r, flashOutEn_n_r, flashWrEn_n_r;
    wire        flashByteWord_r, reset_unprotect_n, unprotHv_r, sigAddrHv_r, ready_busy_n;
    integer     num_errors, checks_done, cnt, w, op;
    fbci_host i_dut (.*, .clkEn(1'b1));
    fbci_flash_model i_flash (.mclk(mclk), .addr(flashAddr_r), .dqOut(flashDqOut_r), .ceN(flashChipEn_n_r),
        .oeN(flashOutEn_n_r), .weN(flashWrEn_n_r), .byteWord(flashByteWord_r), .rstN(reset_unprotect_n),
        .sigHv(sigAddrHv_r), .dqIn(flashDqIn), .rbN(ready_busy_n));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input [19:0] seen, input [19:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge mclk);
            regWr <= 1'b1; regAddr <= a; regWdata <= d;
            @(posedge mclk);
            regWr <= 1'b0;
        end
    endtask
    task rdReg(input [3:0] a);
        begin
            @(posedge mclk);
            regRd <= 1'b1; regAddr <= a;
            @(posedge mclk);
            regRd <= 1'b0;
            #1 rd = regRdata_r;
        end
    endtask
    // start an operation, wait for the sequencer to finish
    task run(input [2:0] o, input [3:0] flags);
        integer n;
        begin
            cnt = i_flash.wrCount;
            wr(`FBCI_REG_CTRL, {8'h00, flags, o, 1'b1});
            n = 0;
            rd = 16'h0001;
            while (rd[0] !== 1'b0 && n < 2000) begin
                rdReg(`FBCI_REG_STATUS);
                n = n + 1;
            end
        end
    endtask
    task waitReady;
        integer n;
        begin
            n = 0;
            rdReg(`FBCI_REG_STATUS);
            while (rd[1:0] !== 2'b10 && n < 2000) begin
                rdReg(`FBCI_REG_STATUS);
                n = n + 1;
            end
            check(rd[1:0], 2'b10);
        end
    endtask
    task setAddr(input [17:0] a, input lsb);
        begin
            wr(`FBCI_REG_ADDR, a[15:0]);
            wr(4'h6, {13'h0000, lsb, a[17:16]});
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_program;
        for (w = 1; w >= 0; w = w - 1) begin
            setAddr(18'h21234, 1'b1);
            wr(`FBCI_REG_WDATA, 16'hBEEF);
            run(`FBCI_OP_PROGRAM, w);
            check(i_flash.wrCount - cnt, 4);
            check(i_flash.progAddr, w ? {1'b0, 18'h21234} : {18'h21234, 1'b1});
            check(i_flash.progData[7:0], 8'hEF);
            waitReady;
            run(`FBCI_OP_READ, w);
            rdReg(`FBCI_REG_RDATA);
            check(w ? rd : rd[7:0], w ? 16'hBEEF : 8'hEF);
        end
    endtask
    task t_erase;
        for (op = 2; op <= 3; op = op + 1) begin
            run(op, 4'h3);
            check(unprotHv_r, 1'b1);
            check(i_flash.wrCount - cnt, 6);
            repeat (4) @(posedge mclk);
            check(ready_busy_n, 1'b0);
            waitReady;
            setAddr(18'h21234, 1'b0);
            run(`FBCI_OP_READ, 4'h1);
            rdReg(`FBCI_REG_RDATA);
            check(rd, 16'hFFFF);
        end
    endtask
    task t_refuse;
        begin
            run(`FBCI_OP_BLKERASE, 4'h1);
            run(`FBCI_OP_PROGRAM, 4'h1);
            check(i_flash.wrCount - cnt, 0);
            rdReg(`FBCI_REG_STATUS);
            check(rd[2], 1'b1);
            wr(`FBCI_REG_STATUS, 16'h0004);
            run(`FBCI_OP_SUSPEND, 4'h1);
            waitReady;
            run(`FBCI_OP_RESUME, 4'h1);
            repeat (4) @(posedge mclk);
            check(ready_busy_n, 1'b0);
            waitReady;
        end
    endtask
    task t_reset;
        begin
            run(`FBCI_OP_BLKERASE, 4'h1);
            run(`FBCI_OP_READ, 4'h9);
            waitReady;
            check(i_flash.lastRst >= `FBCI_RSTPULSE_CYC, 1'b1);
            check(i_flash.cyc, 3'h0);
        end
    endtask
    task t_sig;
        begin
            setAddr(18'h00000, 1'b0);
            run(`FBCI_OP_SIGNATURE, 4'h1);
            rdReg(`FBCI_REG_RDATA);
            check(rd, {8'h00, i_flash.MAKER});
            run(`FBCI_OP_READRESET, 4'h1);
            setAddr(18'h00001, 1'b0);
            run(`FBCI_OP_READ, 4'h5);
            rdReg(`FBCI_REG_RDATA);
            check(rd, {8'h00, i_flash.PART});
        end
    endtask
    task end_of_test;
        begin
            if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        rst_n = 0; regAddr = 0; regWdata = 0; regWr = 0; regRd = 0; num_errors = 0; checks_done = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_program;
        t_erase;
        t_refuse;
        t_reset;
        t_sig;
        end_of_test;
    end
    // cut a hang short
    initial begin
        #1500000;
        num_errors = num_errors + 1;
        end_of_test;
    end
endmodule
